// ---- acal_defs.svh ----
`ifndef ACAL_DEFS_SVH
`define ACAL_DEFS_SVH

// Byte addresses of the control registers
`define ACAL_CTRL_ADDR 12'h000
`define ACAL_STAT_ADDR 12'h004
`define ACAL_TRIM_BASE 12'h010
`define ACAL_TRIM_LAST 12'h024

// Printed register indices; byte address is four times the index
`define ACAL_SRC_DLY_IDX 12'h09a
`define ACAL_MUX_DLY_IDX 12'h09b

// Control register bit positions
`define ACAL_CTRL_TSEL 0
`define ACAL_CTRL_SOFT 1
`define ACAL_CTRL_BGEN 2
`define ACAL_CTRL_FGOS 3
`define ACAL_CTRL_BGOS 4

// Trim field positions within a per-core trim word
`define ACAL_TRIM_OFS_LSB 0
`define ACAL_TRIM_GAIN_LSB 8
`define ACAL_TRIM_TERM_LSB 16

// Reset values
`define ACAL_CTRL_RST 5'h00
`define ACAL_TRIM_RST 24'h804080
`define ACAL_SRC_DLY_RST 8'h00
`define ACAL_MUX_DLY_RST 8'h00
`define ACAL_MID_CODE 9'h000

// Timing: cycles of one calibration run
`define ACAL_CAL_CYCLES 10'd1000

// Core routing codes
`define ACAL_ROUTE_STIM 3'h7
`define ACAL_ROUTE_IDLE 3'h6

`endif

// ---- acal_pkg.sv ----
package acal_pkg;

  // Device variant
  typedef enum logic [1:0]
  {
    ACAL_QUAD = 2'b00,
    ACAL_DUAL = 2'b01,
    ACAL_SINGLE = 2'b10
  } acal_variant_e;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ACAL_FG_CAL = 3'b000,
    ACAL_IDLE = 3'b001,
    ACAL_BG_CAL = 3'b010,
    ACAL_BG_SRC = 3'b011,
    ACAL_BG_MUX = 3'b100
  } acal_state_e;

  // Whole state of the sequencer
  typedef struct packed
  {
    acal_state_e state;
    logic [9:0] cnt;
    logic [1:0] slot;
    logic [3:0][2:0] chanCore;
    logic [1:0][2:0] spare;
    logic pinMeta;
    logic pinSync;
    logic trigPrev;
    logic fgDone;
    logic [4:0] ctrl;
    logic [7:0] srcDly;
    logic [7:0] muxDly;
    logic [5:0][23:0] trim;
    logic [31:0] rdata;
    logic slvErr;
  } acal_state_s;

  // State of one output lane
  typedef struct packed
  {
    logic [8:0] data;
  } acal_lane_s;

endpackage

// ---- acal_out_lane.sv ----
`include "acal_defs.svh"

module acal_out_lane
  import acal_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Core samples and selection
  input wire logic [5:0][8:0] coreSample,
  input wire logic [2:0] coreSel,
  input wire logic mute,
  // Output sample
  output logic [8:0] sampleOut
);

  acal_lane_s st_ff;
  acal_lane_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Whole-sample pick from one core, or mid-code while muted
  always_comb
  begin
    nxt_st = st_ff;
    if (mute || coreSel > 3'd5)
    begin
      nxt_st.data = `ACAL_MID_CODE;
    end
    else
    begin
      nxt_st.data = coreSample[coreSel];
    end
  end

  // Register the lane
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sampleOut = st_ff.data;

endmodule

// ---- acal_cal_ctrl.sv ----
`include "acal_defs.svh"

// Contract
// R1: Two calibration modes: foreground stops conversion, background keeps converting.
// R2: During foreground calibration every output sample is mid-code zero.
// R3: Six converter cores; some active, the rest spares.
// R4: Foreground routing: A to core 0, B to 1, C to 4, D to 5.
// R5: Quad background: core 2 replaces 0 or 1, core 3 replaces 4 or 5.
// R6: Dual: cores 0 and 1 share spare 2; single: core 0 uses 2.
// R7: Calibration trims each bank against an internal stimulus.
// R8: System keeps near-DC content off inputs while offset calibration runs.
// R9: Per-core trims for input offset, gain and termination are adjustable.
// R10: Trims reset to factory values; user writes are accepted and used.
// R11: Foreground calibration runs at power-up; system waits before configuring.
// R12: Foreground starts on trigger from pin or software bit, by select.
// R13: Background rotates: calibrated spare takes over, displaced core is calibrated.
// R14: Background never calibrates more than one core at a time.
// R15: Background needs enable set, select cleared, software trigger set. With select set, the pin trigger also starts it.
// R16: Brief glitches at core exchange are tolerated.
// R17: System should program source delay 0x1F and mux delay 0x1E.
// R18: Core exchange on a sample boundary; no sample dropped or doubled.
module acal_cal_ctrl
  import acal_pkg::*;
#(
  parameter acal_variant_e VARIANT = ACAL_QUAD
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger pin
  input wire logic calibration_trigger_pin,
  // Core samples
  input wire logic [5:0][8:0] coreSample,
  // Output samples per input
  output logic [8:0] chanDataA,
  output logic [8:0] chanDataB,
  output logic [8:0] chanDataC,
  output logic [8:0] chanDataD,
  // Core control
  output logic [5:0][2:0] coreRoute,
  output logic [5:0] calCores,
  output logic offsetCalActive,
  output logic [5:0][23:0] trimOut
);

  acal_state_s st_ff;
  acal_state_s nxt_st;
  logic [3:0][8:0] laneOut;
  logic effTrig;
  logic fgBusy;
  logic bgBusy;
  logic [2:0] calCore;
  logic wrEn;
  logic [11:0] srcAddr;
  logic [11:0] muxAddr;
  logic [3:0][2:0] homeMap;

  assign srcAddr = `ACAL_SRC_DLY_IDX << 2; // Byte address is four times the index
  assign muxAddr = `ACAL_MUX_DLY_IDX << 2;
  assign homeMap = {3'd5, 3'd4, 3'd1, 3'd0}; // R4

  ////////////////////////////////////////////////////////////////////////////
  // Status terms
  assign fgBusy = st_ff.state == ACAL_FG_CAL; // R1
  assign bgBusy = st_ff.state == ACAL_BG_CAL;
  assign calCore = st_ff.spare[st_ff.slot[1]];
  assign effTrig = st_ff.ctrl[`ACAL_CTRL_TSEL] ? st_ff.pinSync
                                              : st_ff.ctrl[`ACAL_CTRL_SOFT]; // R12
  assign wrEn = psel && penable && pwrite;

  // APB handshake: zero wait states
  assign pready = psel && penable;
  assign prdata = st_ff.rdata;
  assign pslverr = pready && st_ff.slvErr;

  ////////////////////////////////////////////////////////////////////////////
  // Next slot in the rotation for this variant
  function automatic logic [1:0] nextSlot(input logic [1:0] s);
    logic [1:0] n;
    n = 2'd0;
    case (VARIANT)
      ACAL_QUAD: n = {~s[1], s[0] ^ s[1]}; // R5
      ACAL_DUAL: n = {1'b0, ~s[0]}; // R6
      default: n = 2'd0; // R6
    endcase
    return n;
  endfunction

  // Read value of a register, and whether the address is mapped
  function automatic logic [32:0] readReg(input logic [11:0] a, input acal_state_s s);
    logic [32:0] r;
    logic [11:0] t;
    r = '0;
    t = a - `ACAL_TRIM_BASE;
    if (a == `ACAL_CTRL_ADDR)
    begin
      r = {1'b1, 27'h0, s.ctrl};
    end
    else if (a == `ACAL_STAT_ADDR)
    begin
      r = {1'b1, 22'h0, s.slot, 1'b0, calCore, 1'b0, bgBusy, fgBusy, s.fgDone};
    end
    else if (a >= `ACAL_TRIM_BASE && a <= `ACAL_TRIM_LAST && a[1:0] == 2'b00)
    begin
      r = {1'b1, 8'h0, s.trim[t[4:2]]}; // R10
    end
    else if (a == srcAddr)
    begin
      r = {1'b1, 24'h0, s.srcDly};
    end
    else if (a == muxAddr)
    begin
      r = {1'b1, 24'h0, s.muxDly};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, trigger sync and register file
  always_comb
  begin
    logic [32:0] rd;
    logic [11:0] toff;
    logic [2:0] oldCore;
    rd = readReg(paddr, st_ff);
    toff = paddr - `ACAL_TRIM_BASE;
    oldCore = st_ff.chanCore[st_ff.slot];
    nxt_st = st_ff;
    nxt_st.pinMeta = calibration_trigger_pin;
    nxt_st.pinSync = st_ff.pinMeta;
    nxt_st.trigPrev = effTrig;
    // Read data and error captured in the setup phase
    if (psel && !penable)
    begin
      nxt_st.rdata = rd[31:0];
      nxt_st.slvErr = !rd[32];
    end
    // Writes take effect at the access edge
    if (wrEn && rd[32])
    begin
      if (paddr == `ACAL_CTRL_ADDR)
      begin
        nxt_st.ctrl = pwdata[4:0];
      end
      else if (paddr == srcAddr)
      begin
        nxt_st.srcDly = pwdata[7:0];
      end
      else if (paddr == muxAddr)
      begin
        nxt_st.muxDly = pwdata[7:0];
      end
      else if (paddr != `ACAL_STAT_ADDR)
      begin
        nxt_st.trim[toff[4:2]] = pwdata[23:0]; // R9 R10
      end
    end
    case (st_ff.state)
      ACAL_FG_CAL:
      begin
        // All cores on stimulus; output muted; home routing restored
        nxt_st.chanCore = homeMap; // R4
        nxt_st.spare = {3'd3, 3'd2};
        nxt_st.slot = 2'd0;
        nxt_st.cnt = st_ff.cnt + 10'd1;
        if (st_ff.cnt == `ACAL_CAL_CYCLES - 10'd1)
        begin
          nxt_st.state = ACAL_IDLE;
          nxt_st.fgDone = 1'b1;
          nxt_st.cnt = '0;
        end
      end
      ACAL_IDLE:
      begin
        nxt_st.cnt = '0;
        if (st_ff.ctrl[`ACAL_CTRL_BGEN] && effTrig)
        begin
          nxt_st.state = ACAL_BG_CAL; // R15
        end
        else if (!st_ff.ctrl[`ACAL_CTRL_BGEN] && effTrig && !st_ff.trigPrev)
        begin
          nxt_st.state = ACAL_FG_CAL; // R12
          nxt_st.fgDone = 1'b0;
        end
      end
      ACAL_BG_CAL:
      begin
        // Only the spare of the current slot's group is calibrated
        nxt_st.cnt = st_ff.cnt + 10'd1; // R14
        if (!st_ff.ctrl[`ACAL_CTRL_BGEN])
        begin
          nxt_st.state = ACAL_IDLE;
        end
        else if (st_ff.cnt == `ACAL_CAL_CYCLES - 10'd1)
        begin
          nxt_st.state = ACAL_BG_SRC;
          nxt_st.cnt = '0;
        end
      end
      ACAL_BG_SRC:
      begin
        // Spare now samples the input alongside the active core
        nxt_st.cnt = st_ff.cnt + 10'd1;
        if (st_ff.cnt >= {2'b00, st_ff.srcDly})
        begin
          nxt_st.state = ACAL_BG_MUX;
          nxt_st.cnt = '0;
        end
      end
      ACAL_BG_MUX:
      begin
        nxt_st.cnt = st_ff.cnt + 10'd1;
        if (st_ff.cnt >= {2'b00, st_ff.muxDly})
        begin
          // Exchange: spare takes the slot, displaced core becomes spare
          nxt_st.chanCore[st_ff.slot] = st_ff.spare[st_ff.slot[1]]; // R13 R18
          nxt_st.spare[st_ff.slot[1]] = oldCore; // R13
          nxt_st.slot = nextSlot(st_ff.slot);
          nxt_st.state = st_ff.ctrl[`ACAL_CTRL_BGEN] ? ACAL_BG_CAL : ACAL_IDLE;
          nxt_st.cnt = '0;
        end
      end
      default:
      begin
        nxt_st.state = ACAL_IDLE;
      end
    endcase
  end

  // Register the state; power-up enters foreground calibration
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
      st_ff.state <= ACAL_FG_CAL; // R11
      st_ff.chanCore <= {3'd5, 3'd4, 3'd1, 3'd0};
      st_ff.spare <= {3'd3, 3'd2};
      st_ff.ctrl <= `ACAL_CTRL_RST;
      st_ff.srcDly <= `ACAL_SRC_DLY_RST;
      st_ff.muxDly <= `ACAL_MUX_DLY_RST;
      st_ff.trim <= {6{`ACAL_TRIM_RST}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core routing: inputs, stimulus or idle for all six cores
  always_comb
  begin
    for (int c = 0; c < 6; c++) // R3
    begin
      coreRoute[c] = `ACAL_ROUTE_IDLE;
      calCores[c] = 1'b0;
      if (fgBusy)
      begin
        coreRoute[c] = `ACAL_ROUTE_STIM; // R7
        calCores[c] = 1'b1;
      end
      else
      begin
        for (int ch = 0; ch < 4; ch++)
        begin
          if (st_ff.chanCore[ch] == 3'(c))
          begin
            coreRoute[c] = 3'(ch);
          end
        end
        if (calCore == 3'(c))
        begin
          if (bgBusy)
          begin
            coreRoute[c] = `ACAL_ROUTE_STIM; // R7
            calCores[c] = 1'b1; // R14
          end
          else if (st_ff.state == ACAL_BG_SRC || st_ff.state == ACAL_BG_MUX)
          begin
            coreRoute[c] = {1'b0, st_ff.slot};
          end
        end
      end
    end
  end

  assign offsetCalActive = (fgBusy && st_ff.ctrl[`ACAL_CTRL_FGOS])
                        || (bgBusy && st_ff.ctrl[`ACAL_CTRL_BGOS]);
  assign trimOut = st_ff.trim; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Output lanes, one per input
  for (genvar g = 0; g < 4; g++)
  begin : gLane
    acal_out_lane uLane
    (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .coreSample(coreSample),
      .coreSel(st_ff.chanCore[g]), // R16 R18
      .mute(fgBusy), // R2
      .sampleOut(laneOut[g])
    );
  end

  assign chanDataA = laneOut[0];
  assign chanDataB = laneOut[1];
  assign chanDataC = laneOut[2];
  assign chanDataD = laneOut[3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence fgStartSeq;
    st_ff.state == ACAL_IDLE && !st_ff.ctrl[`ACAL_CTRL_BGEN] && effTrig && !st_ff.trigPrev;
  endsequence

  sequence swapSeq;
    st_ff.state == ACAL_BG_MUX && st_ff.cnt >= {2'b00, st_ff.muxDly};
  endsequence

  fg_mute_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    fgBusy |=> laneOut == '0)
    else $error("output not mid-code during foreground calibration");

  fg_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    fgBusy ##1 fgBusy |-> st_ff.chanCore == homeMap)
    else $error("foreground routing wrong");

  one_cal_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
    !fgBusy |-> $onehot0(calCores))
    else $error("more than one core calibrating");

  trig_start_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    fgStartSeq |=> fgBusy && !st_ff.fgDone)
    else $error("trigger did not start foreground calibration");

  swap_take_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    swapSeq |=> st_ff.chanCore[$past(st_ff.slot)] == $past(calCore)
      && st_ff.spare[$past(st_ff.slot[1])] == $past(st_ff.chanCore[st_ff.slot]))
    else $error("core exchange wrong");

  spare_group_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    st_ff.spare[0] <= 3'd2 && st_ff.chanCore[0] <= 3'd2 && st_ff.chanCore[1] <= 3'd2
      && st_ff.spare[1] >= 3'd3 && st_ff.chanCore[2] >= 3'd3)
    else $error("core left its group");

  fg_len_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    $rose(st_ff.fgDone) |-> $past(fgBusy) && $past(st_ff.cnt) == `ACAL_CAL_CYCLES - 10'd1)
    else $error("foreground calibration length wrong");

  stim_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    bgBusy |-> coreRoute[calCore] == `ACAL_ROUTE_STIM)
    else $error("calibrating core not on stimulus");

  trim_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    wrEn && paddr == `ACAL_TRIM_BASE |=> trimOut[0] == $past(pwdata[23:0]))
    else $error("trim write not taken");

  sample_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
    swapSeq ##1 !fgBusy |=> chanDataA == $past(coreSample[st_ff.chanCore[0]]))
    else $error("lane did not follow new core on boundary");

endmodule

// ---- acal_sys_model.sv ----
module acal_sys_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Bench command
  input wire logic trigReq,
  // Device status
  input wire logic offsetCalActive,
  // Core samples and trigger pin
  output logic [5:0][8:0] coreSample,
  output logic calibration_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] phase_ff;

  ////////////////////////////////
  // Free running sample phase
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      phase_ff <= 6'h00;
    else
      phase_ff <= phase_ff + 6'h01;
  end

  // Core number in top bits; zero-mean tone while offset is trimmed
  always_comb
  begin
    for (int k = 0; k < 6; k++)
    begin
      if (offsetCalActive)
        coreSample[k] = phase_ff[0] ? 9'h0a5 : 9'h15b;
      else
        coreSample[k] = {3'(k), phase_ff};
    end
  end

  // Trigger pin follows the controller request
  assign calibration_trigger_pin = trigReq;
endmodule

// ---- tb.sv ----
`include "acal_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] SRC_ADDR = 12'(`ACAL_SRC_DLY_IDX * 4);
  localparam logic [11:0] MUX_ADDR = 12'(`ACAL_MUX_DLY_IDX * 4);
  localparam logic [3:0][2:0] HOME_CORE = {3'h5, 3'h4, 3'h1, 3'h0};

  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, errFlag;
  logic trigReq, pin, offsetCalActive, bgOn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [5:0][8:0] coreSample;
  logic [3:0][8:0] chanAll;
  logic [5:0][2:0] coreRoute;
  logic [5:0] calCores, prevA;
  logic [5:0][23:0] trimOut;
  int errors, checkCount;

  ////////////////////////////////
  // Device and system controller
  acal_cal_ctrl i_acal_cal_ctrl (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .calibration_trigger_pin(pin),
    .coreSample(coreSample), .chanDataA(chanAll[0]), .chanDataB(chanAll[1]),
    .chanDataC(chanAll[2]), .chanDataD(chanAll[3]), .coreRoute(coreRoute),
    .calCores(calCores), .offsetCalActive(offsetCalActive), .trimOut(trimOut));

  acal_sys_model i_acal_sys_model (.clk_sys(clk_sys), .resetn(resetn), .trigReq(trigReq),
    .offsetCalActive(offsetCalActive), .coreSample(coreSample),
    .calibration_trigger_pin(pin));

  ////////////////////////////////
  // Reporting
  task fail(string m);
    errors++;
    $display("unexpected %0t %s", $time, m);
  endtask

  task chkReg(logic [31:0] got, logic [31:0] exp, string m);
    checkCount++;
    if (got !== exp)
      fail(m);
  endtask

  task chkSig(logic [8:0] got, logic [8:0] exp, string m);
    checkCount++;
    if (got !== exp)
      fail(m);
  endtask

  task endTest(string m);
    $display("test %s done", m);
  endtask

  task testDone();
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////
  // APB transfer; request held until pready is sampled high
  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail("bus timeout");
      testDone();
    end
    rdData = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(logic [11:0] a, logic [31:0] exp, logic expErr);
    apb(1'b0, a, 32'h00000000);
    chkReg(rdData, exp, "read data");
    chkReg({31'h0, errFlag}, {31'h0, expErr}, "slave error");
  endtask

  // Polls status until masked bits match
  task waitStat(logic [31:0] m, logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `ACAL_STAT_ADDR, 32'h00000000);
      n++;
    end
    while ((rdData & m) !== v && n < 600);
    chkReg(rdData & m, v, "status");
    if ((rdData & m) !== v)
      testDone();
  endtask

  // Source core of a channel, or the calibrating cores
  function automatic logic [8:0] pick(int s);
    return (s < 4) ? {6'h00, chanAll[s][8:6]} : {3'h0, calCores};
  endfunction

  task waitSig(int s, logic [8:0] exp, int lim);
    int n;
    n = 0;
    while (pick(s) !== exp && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chkSig(pick(s), exp, "wait value");
    if (pick(s) !== exp)
      testDone();
  endtask

  ////////////////////////////////
  // Clock, watchdog and background stream monitor
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail("run timeout");
    testDone();
  end

  always @(posedge clk_sys)
  begin
    if (bgOn)
    begin
      chkSig(9'($countones(calCores) > 1), 9'h000, "two cores calibrating");
      chkSig({3'h0, chanAll[0][5:0]}, {3'h0, prevA + 6'h01}, "sample gap");
    end
    prevA = chanAll[0][5:0];
  end

  ////////////////////////////////
  // Test sequence
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    trigReq = 1'b0;
    bgOn = 1'b0;
    errors = 0;
    checkCount = 0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chkSig(chanAll[0], 9'h000, "mid code");
    waitStat(32'h3, 32'h2);
    for (int k = 0; k < 6; k++)
      rd(12'(`ACAL_TRIM_BASE + 4 * k), 32'h00804080, 1'b0);
    rd(SRC_ADDR, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    waitStat(32'h3, 32'h1);
    endTest("power up");

    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 4; k++)
    begin
      chkSig(pick(k), {6'h00, HOME_CORE[k]}, "home source");
      chkSig({6'h00, coreRoute[HOME_CORE[k]]}, 9'(k), "home route");
    end
    apb(1'b1, `ACAL_TRIM_BASE, 32'hffabcdef);
    apb(1'b1, 12'h01c, 32'h00123456);
    rd(`ACAL_TRIM_BASE, 32'h00abcdef, 1'b0);
    rd(12'h01c, 32'h00123456, 1'b0);
    chkReg({8'h00, trimOut[3]}, 32'h00123456, "trim out");
    chkReg({8'h00, trimOut[0]}, 32'h00abcdef, "trim out");
    endTest("routing and trims");

    apb(1'b1, `ACAL_CTRL_ADDR, 32'h3);
    repeat (5) @(posedge clk_sys);
    waitStat(32'h2, 32'h0);
    apb(1'b1, `ACAL_CTRL_ADDR, 32'h9);
    trigReq <= 1'b1;
    waitStat(32'h2, 32'h2);
    trigReq <= 1'b0;
    chkSig(chanAll[1], 9'h000, "mid code");
    chkSig({8'h00, offsetCalActive}, 9'h001, "offset flag");
    waitStat(32'h3, 32'h1);
    endTest("pin trigger");

    apb(1'b1, `ACAL_CTRL_ADDR, 32'h0);
    apb(1'b1, `ACAL_CTRL_ADDR, 32'h2);
    waitStat(32'h2, 32'h2);
    chkSig(chanAll[3], 9'h000, "mid code");
    waitStat(32'h3, 32'h1);
    endTest("soft trigger");

    apb(1'b1, SRC_ADDR, 32'h1f);
    apb(1'b1, MUX_ADDR, 32'h1e);
    rd(SRC_ADDR, 32'h1f, 1'b0);
    rd(MUX_ADDR, 32'h1e, 1'b0);
    apb(1'b1, `ACAL_CTRL_ADDR, 32'h6);
    bgOn <= 1'b1;
    waitSig(4, 9'h004, 20);
    waitSig(0, 9'h002, 1200);
    waitSig(4, 9'h008, 20);
    waitSig(2, 9'h003, 1200);
    waitSig(4, 9'h001, 20);
    waitSig(1, 9'h000, 1200);
    bgOn <= 1'b0;
    endTest("background");
    testDone();
  end
endmodule
